/* logic/windowed_watchdog_regs.sv */
// Windowed watchdog: control registers, prescale counter, window check.
// Assumes a 25 MHz clk, oscillator pins and config straps from outside.
`include "wwdt_defines.svh"
`default_nettype none

// Notes on behaviour
// - Scale code 0 divides by 32; each step doubles, up to code 10010.
// - Scale codes 10011 to 11111 give the shortest interval.
// - Scale resets to 01011 when preset is 11111, else to the preset.
// - Scale field is read-only unless the scale preset is 11111.
// - In enable mode 01 the soft enable bit runs or stops the watchdog.
// - Clock source 000 low oscillator, 001 mid oscillator, others reserved.
// - Clock source resets to 000 with preset 111; locked otherwise.
// - Opening code 111 is fully open; each lower code shrinks by 12.5 percent.
// - Opening resets from its preset; locked unless preset is 111.
// - Window open when timer value is at least four times seven minus code.
// - Armed flag reads at bit 2 of the timer register.
// - 18-bit prescale count readable over low, high and timer registers.
// - Low count byte is read-only and resets to zero.
// - High count byte is read-only and resets to zero.
// - Timer register is read-only and resets to zero.
// - Nominal intervals come from the 31 kHz low oscillator, approximate.
// - Reading control register A arms the watchdog in windowed mode.
// - Clear instruction with the window closed while counting causes a watchdog reset.
// - Clear instruction while counting and not armed causes a watchdog reset when opening code is not 111.
// - Any write with write strobe bit 0 set to either control register clears the counter.
module windowed_watchdog_regs
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire wwdt_pkg::cfg_type    cfgStraps,
  input  wire logic                 lowFreqOsc,
  input  wire logic                 midFreqOsc,
  input  wire logic                 sleepMode,
  input  wire logic                 clearInstruction,
  input  wire wwdt_pkg::axi_req_type axiReq,
  output var  wwdt_pkg::axi_rsp_type axiRsp,
  output logic                      watchdogReset,
  output logic                      sleepWake,
  output logic                      watchdogActive
);
  import wwdt_pkg::*;

  // Input synchronisers
  logic [15:0]   pinSync1_q;
  logic [15:0]   pinSync2_q;
  logic [1:0]    oscLast_q;
  cfg_type       cfgSync;
  logic          lowSync;
  logic          midSync;
  logic          sleepSync;

  // Control registers
  logic [4:0]    scale_q;
  logic          softEnable_q;
  logic [2:0]    clockSource_q;
  logic [2:0]    opening_q;
  cfg_type       cfgHeld_q;

  // Watchdog core
  run_state_type runState_q;
  run_state_type runState_d;
  logic [22:0]   count_q;
  logic [22:0]   count_d;
  logic          armed_q;
  logic          sleepLast_q;
  logic          reset_q;
  logic          wake_q;

  // Bus slave
  logic          awReady_q;
  logic          wReady_q;
  logic          bValid_q;
  logic [1:0]    bResp_q;
  logic [15:0]   awAddr_q;
  logic [31:0]   wData_q;
  logic [3:0]    wStrb_q;
  logic          arReady_q;
  logic          rValid_q;
  logic [31:0]   rData_q;
  logic [1:0]    rResp_q;

  assign cfgSync   = cfg_type'(pinSync2_q[12:0]);
  assign lowSync   = pinSync2_q[13];
  assign midSync   = pinSync2_q[14];
  assign sleepSync = pinSync2_q[15];

  // Synchroniser runs through reset so straps reach the capture
  always_ff @(posedge clk)
  begin
    pinSync1_q <= {sleepMode, midFreqOsc, lowFreqOsc, cfgStraps};
    pinSync2_q <= pinSync1_q;
  end

  // Oscillator edge ticks
  wire lowTick = lowSync & ~oscLast_q[0];
  wire midTick = midSync & ~oscLast_q[1];
  wire tick = (clockSource_q == `CLKSRC_LOW_FREQ) ? lowTick :
              (clockSource_q == `CLKSRC_MID_FREQ) ? midTick : 1'b0;

  // Write and read decode
  wire awTaken   = axiReq.awvalid & awReady_q;
  wire wTaken    = axiReq.wvalid & wReady_q;
  wire arTaken   = axiReq.arvalid & arReady_q;
  wire awHave    = awTaken | ~awReady_q;
  wire wHave     = wTaken | ~wReady_q;
  wire writeGo   = awHave & wHave & ~bValid_q;
  wire [15:0] wrAddr  = awTaken ? axiReq.awaddr : awAddr_q;
  wire [31:0] wrData  = wTaken ? axiReq.wdata : wData_q;
  wire [3:0]  wrStrb  = wTaken ? axiReq.wstrb : wStrb_q;
  wire [13:0] wrIndex = wrAddr[15:2];
  wire [13:0] rdIndex = axiReq.araddr[15:2];
  wire wrCtrlA   = writeGo & (wrIndex == 14'(`IDX_CONTROL_A)) & wrStrb[0];
  wire wrCtrlB   = writeGo & (wrIndex == 14'(`IDX_CONTROL_B)) & wrStrb[0];
  wire wrMapped  = (wrIndex >= 14'(`IDX_CONTROL_A)) & (wrIndex <= 14'(`IDX_TIMER_STATUS));
  wire rdMapped  = (rdIndex >= 14'(`IDX_CONTROL_A)) & (rdIndex <= 14'(`IDX_TIMER_STATUS));
  wire rdCtrlA   = arTaken & (rdIndex == 14'(`IDX_CONTROL_A));

  // Locks from the held configuration
  wire scaleOpen   = cfgHeld_q.scalePreset == `SCALE_UNLOCKED;
  wire clockOpen   = cfgHeld_q.clockPreset == `CLKSRC_UNLOCKED;
  wire openingOpen = cfgHeld_q.openingPreset == `OPENING_UNLOCKED;

  // Reset values from straps
  wire [4:0] scaleReset = (cfgSync.scalePreset == `SCALE_UNLOCKED) ?
                          `SCALE_DEFAULT : cfgSync.scalePreset;
  wire [2:0] clockReset = (cfgSync.clockPreset == `CLKSRC_UNLOCKED) ?
                          `CLKSRC_DEFAULT : cfgSync.clockPreset;

  // Timeout ratio and window value
  wire [4:0]  scaleEff  = (scale_q > `SCALE_LAST_VALID) ? `SCALE_MIN : scale_q;
  wire [22:0] ratioLast = (`BASE_RATIO << scaleEff) - 23'h000001;
  wire [22:0] scaledDown = count_q >> scaleEff;
  wire [4:0]  windowValue = scaledDown[4:0];
  wire [2:0]  closedSpan = 3'h7 - opening_q;
  wire        windowOpen = windowValue >= {closedSpan, 2'b00};
  wire        windowed   = opening_q != `OPENING_FULL;

  // Enable mode decode
  logic runWanted;
  always_comb
  begin
    unique case (cfgHeld_q.enableMode)
      `MODE_OFF:        runWanted = 1'b0;
      `MODE_SOFT:       runWanted = softEnable_q;
      `MODE_AWAKE_ONLY: runWanted = ~sleepSync;
      default:          runWanted = 1'b1;
    endcase
  end

  // Clear instruction checks
  wire clearBad   = clearInstruction & (runState_q == COUNTING) &
                    ((windowed & ~armed_q) | ~windowOpen);
  wire clearGood  = clearInstruction & ~clearBad;
  wire timeoutHit = (runState_q == COUNTING) & tick & (count_q == ratioLast);
  wire sleepEdge  = sleepSync ^ sleepLast_q;
  wire counterClr = clearGood | wrCtrlA | wrCtrlB | sleepEdge |
                    timeoutHit | clearBad;

  always_comb
  begin
    runState_d = runWanted ? COUNTING : STOPPED;
    count_d    = count_q;
    if (runState_q == STOPPED || counterClr)
      count_d = 23'h000000;
    else if (tick)
      count_d = count_q + 23'h000001;
  end

  // Register read mux
  logic [7:0] rdByte;
  always_comb
  begin
    rdByte = 8'h00;
    unique case (rdIndex)
      14'(`IDX_CONTROL_A):    rdByte = {2'b00, scale_q, softEnable_q};
      14'(`IDX_CONTROL_B):    rdByte = {1'b0, clockSource_q, 1'b0, opening_q};
      14'(`IDX_COUNT_LOW):    rdByte = count_q[7:0];
      14'(`IDX_COUNT_HIGH):   rdByte = count_q[15:8];
      14'(`IDX_TIMER_STATUS): rdByte = {windowValue, armed_q, count_q[17:16]};
      default:                rdByte = 8'h00;
    endcase
  end

  // Control registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfgHeld_q     <= cfgSync;
      scale_q       <= scaleReset;
      softEnable_q  <= 1'b0;
      clockSource_q <= clockReset;
      opening_q     <= cfgSync.openingPreset;
    end
    else
    begin
      if (wrCtrlA && scaleOpen)
        scale_q <= wrData[`SCALE_MSB:`SCALE_LSB];
      if (wrCtrlA)
        softEnable_q <= wrData[`SOFT_EN_BIT];
      if (wrCtrlB && clockOpen)
        clockSource_q <= wrData[`CLKSRC_MSB:`CLKSRC_LSB];
      if (wrCtrlB && openingOpen)
        opening_q <= wrData[`OPENING_MSB:`OPENING_LSB];
    end
  end

  // Watchdog core
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      runState_q  <= STOPPED;
      count_q     <= 23'h000000;
      armed_q     <= 1'b0;
      oscLast_q   <= 2'b00;
      sleepLast_q <= 1'b0;
      reset_q     <= 1'b0;
      wake_q      <= 1'b0;
    end
    else
    begin
      runState_q  <= runState_d;
      count_q     <= count_d;
      oscLast_q   <= {midSync, lowSync};
      sleepLast_q <= sleepSync;
      if (rdCtrlA)
        armed_q <= 1'b1;
      else if (clearInstruction || counterClr || runState_q == STOPPED)
        armed_q <= 1'b0;
      reset_q <= clearBad | (timeoutHit & ~sleepSync);
      wake_q  <= timeoutHit & sleepSync;
    end
  end

  // AXI4-Lite write channel
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awReady_q <= 1'b1;
      wReady_q  <= 1'b1;
      bValid_q  <= 1'b0;
      bResp_q   <= `RESP_OKAY;
      awAddr_q  <= 16'h0000;
      wData_q   <= 32'h00000000;
      wStrb_q   <= 4'h0;
    end
    else
    begin
      if (awTaken)
      begin
        awAddr_q  <= axiReq.awaddr;
        awReady_q <= 1'b0;
      end
      if (wTaken)
      begin
        wData_q  <= axiReq.wdata;
        wStrb_q  <= axiReq.wstrb;
        wReady_q <= 1'b0;
      end
      if (writeGo)
      begin
        bValid_q <= 1'b1;
        bResp_q  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bValid_q && axiReq.bready)
      begin
        bValid_q  <= 1'b0;
        awReady_q <= 1'b1;
        wReady_q  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h00000000;
      rResp_q   <= `RESP_OKAY;
    end
    else if (arTaken)
    begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b1;
      rData_q   <= {24'h000000, rdByte};
      rResp_q   <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rValid_q && axiReq.rready)
    begin
      rValid_q  <= 1'b0;
      arReady_q <= 1'b1;
    end
  end

  always_comb
  begin
    axiRsp.awready = awReady_q;
    axiRsp.wready  = wReady_q;
    axiRsp.bvalid  = bValid_q;
    axiRsp.bresp   = bResp_q;
    axiRsp.arready = arReady_q;
    axiRsp.rvalid  = rValid_q;
    axiRsp.rdata   = rData_q;
    axiRsp.rresp   = rResp_q;
  end

  assign watchdogReset  = reset_q;
  assign sleepWake      = wake_q;
  assign watchdogActive = runState_q[1];
endmodule : windowed_watchdog_regs

`default_nettype wire

/* logic/wwdt_defines.svh */
// Constants of the windowed watchdog register block.
// Assumes inclusion by its bare name from design and checker files.
`ifndef WWDT_DEFINES_SVH
`define WWDT_DEFINES_SVH

// Register indexes; byte address is four times the index
`define IDX_CONTROL_A       16'h0ECD
`define IDX_CONTROL_B       16'h0ECE
`define IDX_COUNT_LOW       16'h0ECF
`define IDX_COUNT_HIGH      16'h0ED0
`define IDX_TIMER_STATUS    16'h0ED1
`define ADDR_WIDTH          16
// Field positions
`define SCALE_MSB           5
`define SCALE_LSB           1
`define SOFT_EN_BIT         0
`define CLKSRC_MSB          6
`define CLKSRC_LSB          4
`define OPENING_MSB         2
`define OPENING_LSB         0
// Reset and decode values
`define SCALE_DEFAULT       5'h0B
`define SCALE_UNLOCKED      5'h1F
`define SCALE_LAST_VALID    5'h12
`define SCALE_MIN           5'h00
`define CLKSRC_UNLOCKED     3'h7
`define CLKSRC_DEFAULT      3'h0
`define CLKSRC_LOW_FREQ     3'h0
`define CLKSRC_MID_FREQ     3'h1
`define OPENING_UNLOCKED    3'h7
`define OPENING_FULL        3'h7
`define MODE_SOFT           2'h1
`define MODE_OFF            2'h0
`define MODE_AWAKE_ONLY     2'h2
`define BASE_RATIO          23'h000020
`define LOW_FREQ_OSC_KHZ    31
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* logic/wwdt_pkg.sv */
// Types of the windowed watchdog register block.
// Assumes the constants header is on the include path.
`default_nettype none
package wwdt_pkg;
  typedef struct packed {
    logic [1:0] enableMode;
    logic [4:0] scalePreset;
    logic [2:0] clockPreset;
    logic [2:0] openingPreset;
  } cfg_type;

  typedef struct packed {
    logic        awvalid;
    logic [15:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [15:0] araddr;
    logic        rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

  typedef enum logic [1:0] {
    STOPPED  = 2'b01,
    COUNTING = 2'b10
  } run_state_type;
endpackage : wwdt_pkg
`default_nettype wire

/* verif/windowed_watchdog_properties.sv */
// Checker of the watchdog register block ports.
// Assumes a bind onto the top module.
`include "wwdt_defines.svh"
`default_nettype none
module windowed_watchdog_properties
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire wwdt_pkg::cfg_type     cfgStraps,
  input wire logic                  clearInstruction,
  input wire wwdt_pkg::axi_req_type axiReq,
  input wire wwdt_pkg::axi_rsp_type axiRsp,
  input wire logic                  watchdogReset,
  input wire logic                  watchdogActive
);
  import wwdt_pkg::*;
  wire logic [15:0] arIdx = axiReq.araddr >> 2;
  wire logic arTake = axiReq.arvalid && axiRsp.arready;
  wire logic wTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  wire logic inMap = axiReq.araddr[1:0] == 2'h0 && arIdx >= `IDX_CONTROL_A && arIdx <= `IDX_TIMER_STATUS;
  wire logic softWr = wTake && axiReq.awaddr == 16'h3B34 && axiReq.wstrb[0] && cfgStraps.enableMode == `MODE_SOFT;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (arTake |=> axiRsp.rvalid && !axiRsp.arready)
    else $error("read answer missing");
  a_write_answer: assert property (wTake |=> axiRsp.bvalid && !axiRsp.awready && !axiRsp.wready)
    else $error("write answer missing");
  a_unmapped_err: assert property (arTake && !inMap |=> axiRsp.rresp == `RESP_SLVERR && axiRsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (arTake && inMap |=> axiRsp.rresp == `RESP_OKAY && axiRsp.rdata[31:8] == 24'h0)
    else $error("mapped read wrong");
  a_reset_pulse: assert property (watchdogReset |=> !watchdogReset)
    else $error("reset pulse too long");
  a_soft_stop: assert property (softWr && !axiReq.wdata[0] |-> ##[1:3] !watchdogActive)
    else $error("soft stop ignored");
  a_soft_run: assert property (softWr && axiReq.wdata[0] |-> ##[1:3] watchdogActive)
    else $error("soft run ignored");
  a_stopped_quiet: assert property (clearInstruction && !watchdogActive |=> !watchdogReset)
    else $error("clear while stopped");
endmodule : windowed_watchdog_properties
bind windowed_watchdog_regs windowed_watchdog_properties windowed_watchdog_properties_inst (
  .clk(clk), .rst(rst), .cfgStraps(cfgStraps), .clearInstruction(clearInstruction),
  .axiReq(axiReq), .axiRsp(axiRsp), .watchdogReset(watchdogReset), .watchdogActive(watchdogActive));
`default_nettype wire

/* verif/cpu_model.sv */
// CPU side model: clear instruction pulses and oscillator ticks.
// Assumes calls right after a rising clk edge.
`default_nettype none
module cpu_model
(
  input  wire logic clk,
  output logic      clearInstruction,
  output logic      lowFreqOsc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    clearInstruction = 1'b0;
    lowFreqOsc = 1'b0;
  end
  // One-cycle clear pulse, then one idle cycle
  task automatic clr();
    clearInstruction <= 1'b1;
    @(posedge clk);
    clearInstruction <= 1'b0;
    @(posedge clk);
  endtask : clr
  task automatic tick(input int k);
    repeat (k)
    begin
      lowFreqOsc <= 1'b1;
      repeat (3) @(posedge clk);
      lowFreqOsc <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : tick
endmodule : cpu_model
`default_nettype wire

/* verif/tb.sv */
// Testbench of the watchdog register block.
// Assumes the CPU model and the bound checker.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wwdt_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        clearInstruction, lowFreqOsc, watchdogReset, watchdogActive;
  axi_req_type axiReq = '0;
  axi_rsp_type axiRsp, s;
  cfg_type     cfgStraps = '{2'h1, 5'h1F, 3'h7, 3'h6};
  int          bad_count = 0;
  int          n_compared = 0;
  int          rstSeen = 0;
  localparam logic [15:0] CtlA = 16'h3B34;
  localparam logic [15:0] CtlB = 16'h3B38;
  localparam logic [15:0] Lo = 16'h3B3C;
  initial forever #20 clk = ~clk;
  always @(negedge clk) s = axiRsp;
  always @(posedge clk) if (watchdogReset === 1'b1) rstSeen <= rstSeen + 1;
  cpu_model cpu_model_inst (.clk(clk), .clearInstruction(clearInstruction), .lowFreqOsc(lowFreqOsc));
  windowed_watchdog_regs windowed_watchdog_regs_inst (.clk(clk), .rst(rst), .cfgStraps(cfgStraps),
    .lowFreqOsc(lowFreqOsc), .midFreqOsc(1'b0), .sleepMode(1'b0), .clearInstruction(clearInstruction),
    .axiReq(axiReq), .axiRsp(axiRsp), .watchdogReset(watchdogReset), .sleepWake(),
    .watchdogActive(watchdogActive));
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    int n = 0;
    r = 2'h3;
    axiReq.awaddr <= a;
    axiReq.wdata <= {24'h0, d};
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    while (r === 2'h3 && n < 50)
    begin
      @(posedge clk);
      n++;
      if (s.awready) axiReq.awvalid <= 1'b0;
      if (s.wready) axiReq.wvalid <= 1'b0;
      if (s.bvalid) r = s.bresp;
    end
    axiReq.bready <= 1'b0;
    if (r === 2'h3)
    begin
      bad_count++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic [1:0] r);
    int n = 0;
    r = 2'h3;
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    while (r === 2'h3 && n < 50)
    begin
      @(posedge clk);
      n++;
      if (s.arready) axiReq.arvalid <= 1'b0;
      if (s.rvalid) {r, d} = {s.rresp, s.rdata[7:0]};
    end
    axiReq.rready <= 1'b0;
    if (r === 2'h3)
    begin
      bad_count++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask : rd
  task automatic t_regs();
    logic [7:0] d;
    logic [1:0] r;
    logic [7:0] rv [5] = '{8'h16, 8'h06, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      rd(16'((`IDX_CONTROL_A + i) * 4), d, r);
      chk("resetValue", rv[i], d);
    end
    wr(CtlA, 8'hFF, r);
    rd(CtlA, d, r);
    chk("controlA", 8'h3F, d);
    wr(CtlB, 8'h91, r);
    rd(CtlB, d, r);
    chk("controlB", 8'h16, d);
    wr(CtlA, 8'h01, r);
    cpu_model_inst.tick(40);
    chk("midSource", 8'h00, 8'(rstSeen));
    wr(CtlB, 8'h00, r);
    wr(Lo, 8'hFF, r);
    rd(Lo, d, r);
    chk("countLow", 8'h00, d);
    rd(16'h0000, d, r);
    chk("unmapped", 8'h02, 8'(r));
  endtask : t_regs
  task automatic t_timeout();
    logic [1:0] r;
    logic [4:0] c [3] = '{5'h00, 5'h01, 5'h13};
    int b;
    for (int i = 0; i < 3; i++)
    begin
      wr(CtlA, {2'h0, c[i], 1'b1}, r);
      b = rstSeen;
      cpu_model_inst.tick(i == 1 ? 63 : 31);
      chk("early", 8'(b), 8'(rstSeen));
      cpu_model_inst.tick(1);
      chk("timeout", 8'(b + 1), 8'(rstSeen));
    end
  endtask : t_timeout
  task automatic t_window();
    logic [7:0] d;
    logic [1:0] r;
    int b;
    wr(CtlA, 8'h01, r);
    b = rstSeen;
    cpu_model_inst.clr();
    repeat (3) @(posedge clk);
    chk("unarmed", 8'(b + 1), 8'(rstSeen));
    rd(CtlA, d, r);
    cpu_model_inst.clr();
    rd(CtlA, d, r);
    cpu_model_inst.tick(5);
    rd(16'h3B44, d, r);
    chk("timer", 8'h2C, d);
    rd(Lo, d, r);
    chk("countLow", 8'h05, d);
    cpu_model_inst.clr();
    wr(CtlA, 8'h00, r);
    cpu_model_inst.clr();
    repeat (3) @(posedge clk);
    chk("closed", 8'(b + 2), 8'(rstSeen));
    chk("active", 8'h00, 8'(watchdogActive));
  endtask : t_window
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_timeout();
    t_window();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
